// file: tick_pkg.sv
/*
 * constants for the system tick and interrupt block: register map,
 * field positions, reset values and startup counts.
 * assumes a 20 MHz core clock and a 32-bit apb master.
 */
package tick_pkg;
    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [11:0] OFF_SEC_PERIOD = 12'h0_0f9 << 2;
    localparam logic [11:0] OFF_MS_PERIOD = 12'h0_0fa << 2;
    localparam logic [11:0] OFF_MS_DIV_LOW = 12'h0_0fc << 2;
    localparam logic [11:0] OFF_MS_DIV_HIGH = 12'h0_0fd << 2;
    localparam logic [11:0] OFF_HMS_DIV = 12'h0_0fe << 2;
    localparam logic [11:0] OFF_WDOG_CTRL = 12'h0_0ff << 2;
    localparam logic [11:0] OFF_AUX_ENABLE = 12'h0_0f0 << 2;
    localparam logic [11:0] OFF_EXT_CTRL = 12'h0_0f1 << 2;
    localparam logic [11:0] OFF_AUX_PENDING = 12'h0_0f2 << 2;
    localparam logic [11:0] OFF_STATUS = 12'h0_0f3 << 2;

    // ****************************************
    // fields
    // ****************************************
    localparam int BIT_LOAD_NOW = 7;
    localparam int BIT_MS_EN = 4;
    localparam int BIT_SEC_EN = 7;
    localparam int BIT_AUX_GLOBAL = 5;
    localparam int BIT_PEND_MS = 0;
    localparam int BIT_PEND_SEC = 1;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [15:0] RST_MS_DIV = 16'h4_e1f;
    localparam logic [7:0] RST_HMS_DIV = 8'h63;
    localparam logic [6:0] RST_PERIOD = 7'h00;
    localparam logic [7:0] RST_WDOG = 8'h00;

    // ****************************************
    // startup timing
    // ****************************************
    localparam int CLK_NS = 50;
    localparam int POR_BITS = 17;
    localparam int PULLUP_MAX_NS = 5000;
    localparam int PULLUP_MAX_CYC = (PULLUP_MAX_NS / CLK_NS) < 1 ? 1 : PULLUP_MAX_NS / CLK_NS;
    localparam int DRIVE_MARGIN_CYC = 512;

    typedef enum {
        ST_HOLD,
        ST_RUN
    } boot_e;
endpackage

// file: system_tick_interrupts.sv
/*
 * system tick chain: millisecond divider, hundred-ms tick, millisecond
 * and seconds auxiliary interrupts, watchdog time base, power-on delay
 * and the strobe / address-latch pull-up handling around reset.
 * assumes an apb master on core_clk and pins synchronous to core_clk.
 */
`timescale 1ns/1ns
// Functional notes
// R1: ms tick = clock divided by setting plus one
// R2: ms interrupt needs own and global enable
// R3: ms interrupt every period plus one ticks
// R4: bit7 loads ms period now, else at expiry
// R5: 100ms tick every divider plus one ms ticks
// R6: 100ms tick never reaches a pin
// R7: seconds interrupt needs own and global enable
// R8: seconds interrupt every period plus one ticks
// R9: bit7 loads seconds period now, else at expiry
// R10: watchdog counts in 100ms tick units
// R11: hold operation through full 17-bit count
// R12: sample external-access input at power-on reset
// R13: weak pull-ups on strobe and latch in reset
// R14: after startup, drive pins, drop pull-ups
// R15: ignore external-access in flash programming mode
// R16: drive pins within 2^17 plus 512 clocks
// R17: outside holds mode inputs through startup
// R18: pull-ups on within 5 us of reset
// R19: interrupts latch pending flags, software clears
module system_tick_interrupts
    import tick_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pins
    input wire logic external_code_select_pin,
    input wire logic strobe_pin_in,
    input wire logic latch_pin_in,
    input wire logic cpu_strobe,
    input wire logic cpu_latch,
    output logic strobe_pin_out,
    output logic strobe_pin_oe,
    output logic strobe_pullup,
    output logic latch_pin_out,
    output logic latch_pin_oe,
    output logic latch_pullup,
    // system
    output logic core_run,
    output logic code_secure,
    output logic flash_prog_mode,
    output logic aux_irq,
    output logic watchdog_tick,
    output logic [7:0] watchdog_period
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [15:0] ms_div;
        logic [15:0] ms_cnt;
        logic [7:0] hms_div;
        logic [7:0] hms_cnt;
        logic [6:0] ms_period;
        logic [6:0] ms_pend_period;
        logic ms_pend_valid;
        logic [6:0] ms_cnt_int;
        logic [6:0] sec_period;
        logic [6:0] sec_pend_period;
        logic sec_pend_valid;
        logic [6:0] sec_cnt_int;
        logic [7:0] wdog;
        logic [7:0] aux_en;
        logic [7:0] ext_ctrl;
        logic [1:0] pending;
        logic [POR_BITS-1:0] por_cnt;
        boot_e boot;
        logic secure;
        logic prog_mode;
        logic sampled;
        logic irq;
        logic wd_tick;
        logic strobe_out;
        logic latch_out;
        logic run;
        logic hold;
    } state_s;

    state_s r;
    state_s next_r;
    logic wr;
    logic rd_phase;
    logic ms_tick;
    logic hms_tick;
    logic ms_fire;
    logic sec_fire;

    always_comb
    begin
        next_r = r;
        wr = psel && penable && pwrite && r.pready;
        rd_phase = psel && !penable;
        ms_tick = 1'b0;
        hms_tick = 1'b0;
        ms_fire = 1'b0;
        sec_fire = 1'b0;

        // ****************************************
        // startup sequence
        // ****************************************
        case (r.boot)
            ST_HOLD:
            begin
                // mode pins are only trusted while the counter runs
                if (!r.sampled)
                begin
                    next_r.sampled = 1'b1;
                    next_r.prog_mode = !strobe_pin_in || !latch_pin_in; // R13
                end
                if (r.por_cnt == {POR_BITS{1'b1}}) // R11 R16
                begin
                    next_r.boot = ST_RUN;
                    // in programming mode the access pin has no say
                    next_r.secure = r.prog_mode ? 1'b0 : external_code_select_pin; // R12 R15
                end
                else
                begin
                    next_r.por_cnt = r.por_cnt + 1'b1;
                end
            end
            ST_RUN:
            begin
                next_r.strobe_out = cpu_strobe; // R14
                next_r.latch_out = cpu_latch; // R14
            end
            default:
            begin
                next_r.boot = ST_HOLD;
            end
        endcase
        // registered copies keep decode glitches off the pins
        next_r.run = next_r.boot == ST_RUN; // R14
        next_r.hold = next_r.boot != ST_RUN; // R13

        // ****************************************
        // tick chain, idle until startup ends
        // ****************************************
        if (r.boot == ST_RUN)
        begin
            if (r.ms_cnt >= r.ms_div) // R1
            begin
                next_r.ms_cnt = 16'h0_000;
                ms_tick = 1'b1;
            end
            else
            begin
                next_r.ms_cnt = r.ms_cnt + 1'b1;
            end
        end
        if (ms_tick)
        begin
            if (r.hms_cnt >= r.hms_div) // R5
            begin
                next_r.hms_cnt = 8'h00;
                hms_tick = 1'b1;
            end
            else
            begin
                next_r.hms_cnt = r.hms_cnt + 1'b1;
            end
            if (r.ms_cnt_int >= r.ms_period) // R3
            begin
                ms_fire = 1'b1;
                next_r.ms_cnt_int = 7'h00;
                if (r.ms_pend_valid) // R4
                begin
                    next_r.ms_period = r.ms_pend_period;
                    next_r.ms_pend_valid = 1'b0;
                end
            end
            else
            begin
                next_r.ms_cnt_int = r.ms_cnt_int + 1'b1;
            end
        end
        if (hms_tick)
        begin
            if (r.sec_cnt_int >= r.sec_period) // R8
            begin
                sec_fire = 1'b1;
                next_r.sec_cnt_int = 7'h00;
                if (r.sec_pend_valid) // R9
                begin
                    next_r.sec_period = r.sec_pend_period;
                    next_r.sec_pend_valid = 1'b0;
                end
            end
            else
            begin
                next_r.sec_cnt_int = r.sec_cnt_int + 1'b1;
            end
        end
        // 100ms tick stays internal, only the seconds counter and the watchdog see it
        next_r.wd_tick = hms_tick; // R6 R10

        // ****************************************
        // apb access
        // ****************************************
        next_r.pready = rd_phase;
        // error flag stands only beside pready
        next_r.pslverr = 1'b0;
        if (rd_phase)
        begin
            case (paddr)
                OFF_SEC_PERIOD: next_r.prdata = {25'h0, r.sec_period};
                OFF_MS_PERIOD: next_r.prdata = {25'h0, r.ms_period};
                OFF_MS_DIV_LOW: next_r.prdata = {24'h0, r.ms_div[7:0]};
                OFF_MS_DIV_HIGH: next_r.prdata = {24'h0, r.ms_div[15:8]};
                OFF_HMS_DIV: next_r.prdata = {24'h0, r.hms_div};
                OFF_WDOG_CTRL: next_r.prdata = {24'h0, r.wdog};
                OFF_AUX_ENABLE: next_r.prdata = {24'h0, r.aux_en};
                OFF_EXT_CTRL: next_r.prdata = {24'h0, r.ext_ctrl};
                OFF_AUX_PENDING: next_r.prdata = {30'h0, r.pending};
                OFF_STATUS: next_r.prdata = {29'h0, r.prog_mode, r.secure, r.boot == ST_RUN};
                default:
                begin
                    next_r.prdata = 32'h0000_0000;
                    next_r.pslverr = 1'b1;
                end
            endcase
        end
        if (wr)
        begin
            case (paddr)
                OFF_SEC_PERIOD:
                begin
                    if (pwdata[BIT_LOAD_NOW]) // R9
                    begin
                        next_r.sec_period = pwdata[6:0];
                        next_r.sec_cnt_int = 7'h00;
                        next_r.sec_pend_valid = 1'b0;
                    end
                    else
                    begin
                        next_r.sec_pend_period = pwdata[6:0];
                        next_r.sec_pend_valid = 1'b1;
                    end
                end
                OFF_MS_PERIOD:
                begin
                    if (pwdata[BIT_LOAD_NOW]) // R4
                    begin
                        next_r.ms_period = pwdata[6:0];
                        next_r.ms_cnt_int = 7'h00;
                        next_r.ms_pend_valid = 1'b0;
                    end
                    else
                    begin
                        next_r.ms_pend_period = pwdata[6:0];
                        next_r.ms_pend_valid = 1'b1;
                    end
                end
                OFF_MS_DIV_LOW: next_r.ms_div[7:0] = pwdata[7:0];
                OFF_MS_DIV_HIGH: next_r.ms_div[15:8] = pwdata[7:0];
                OFF_HMS_DIV: next_r.hms_div = pwdata[7:0];
                OFF_WDOG_CTRL: next_r.wdog = pwdata[7:0];
                OFF_AUX_ENABLE: next_r.aux_en = pwdata[7:0];
                OFF_EXT_CTRL: next_r.ext_ctrl = pwdata[7:0];
                // write one to clear
                OFF_AUX_PENDING: next_r.pending = r.pending & ~pwdata[1:0]; // R19
                default: next_r.pending = r.pending;
            endcase
        end
        // set wins over a clear in the same cycle
        if (ms_fire)
        begin
            next_r.pending[BIT_PEND_MS] = 1'b1; // R19
        end
        if (sec_fire)
        begin
            next_r.pending[BIT_PEND_SEC] = 1'b1; // R19
        end

        next_r.irq = r.ext_ctrl[BIT_AUX_GLOBAL]
            && ((r.aux_en[BIT_MS_EN] && r.pending[BIT_PEND_MS]) // R2
            || (r.aux_en[BIT_SEC_EN] && r.pending[BIT_PEND_SEC])); // R7
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            // pull-ups come on at the first edge with reset low
            r <= '{
                prdata: 32'h0000_0000,
                ms_div: RST_MS_DIV,
                hms_div: RST_HMS_DIV,
                ms_period: RST_PERIOD,
                sec_period: RST_PERIOD,
                wdog: RST_WDOG,
                boot: ST_HOLD,
                hold: 1'b1,
                default: '0
            }; // R18
        end
        else
        begin
            r <= next_r;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign strobe_pin_out = r.strobe_out;
    assign latch_pin_out = r.latch_out;
    assign strobe_pin_oe = r.run; // R14
    assign latch_pin_oe = r.run;
    assign strobe_pullup = r.hold; // R13
    assign latch_pullup = r.hold;
    assign core_run = r.run;
    assign code_secure = r.secure;
    assign flash_prog_mode = r.prog_mode;
    assign aux_irq = r.irq;
    assign watchdog_tick = r.wd_tick;
    assign watchdog_period = r.wdog;
endmodule

// file: system_tick_interrupts_props.sv
/* port checker for the system tick block.
   assumes one clock domain, core_clk with synchronous rstn. */
`timescale 1ns/1ns
module system_tick_interrupts_chk
    import tick_pkg::*;
(
    // watched ports
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic cpu_strobe,
    input wire logic cpu_latch,
    input wire logic strobe_pin_out,
    input wire logic latch_pin_out,
    input wire logic strobe_pin_oe,
    input wire logic strobe_pullup,
    input wire logic latch_pin_oe,
    input wire logic latch_pullup,
    input wire logic core_run,
    input wire logic code_secure,
    input wire logic flash_prog_mode,
    input wire logic watchdog_tick
);
    // ****************************************
    // startup cycle count
    // ****************************************
    logic [17:0] boot_cnt;
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            boot_cnt <= '0;
        else if (!core_run)
            boot_cnt <= boot_cnt + 18'h0_0001;
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    a_ready_after_setup: assert property (s_setup |=> s_access ##1 !pready)
        else $error("pready not one cycle after setup");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_pullup_in_reset: assert property (disable iff (1'b0) !rstn |=> strobe_pullup && latch_pullup)
        else $error("pull-ups off after reset");
    a_pins_track_run: assert property (strobe_pin_oe == core_run && latch_pin_oe == core_run && strobe_pullup == !core_run)
        else $error("pin enables disagree with run state");
    a_boot_short: assert property ($rose(core_run) |-> boot_cnt >= 18'h1_fffe)
        else $error("startup ended early");
    a_boot_long: assert property (!core_run |-> boot_cnt <= 18'h2_0200)
        else $error("startup too long");
    a_pin_follows: assert property (core_run && $past(core_run) |-> strobe_pin_out == $past(cpu_strobe))
        else $error("strobe pin not following cpu");
    a_latch_follows: assert property (core_run && $past(core_run) |-> latch_pin_out == $past(cpu_latch))
        else $error("latch pin not following cpu");
    a_prog_no_secure: assert property (flash_prog_mode |-> !code_secure)
        else $error("access pin used in programming mode");
    a_tick_after_boot: assert property (watchdog_tick |-> core_run)
        else $error("watchdog tick during startup");
endmodule
bind system_tick_interrupts system_tick_interrupts_chk u_chk (.core_clk, .rstn, .psel, .penable,
    .pready, .pslverr, .cpu_strobe, .cpu_latch, .strobe_pin_out, .latch_pin_out, .strobe_pin_oe,
    .strobe_pullup, .latch_pin_oe, .latch_pullup, .core_run, .code_secure, .flash_prog_mode,
    .watchdog_tick);

// file: test_system_tick_interrupts.sv
/* self-checking bench for the system tick block over apb.
   assumes tick_pkg reset values and a 50 ns core clock. */
`timescale 1ns/1ns
module test_system_tick_interrupts;
    import tick_pkg::*;
    localparam int MSD = 10;
    logic core_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic external_code_select_pin = 1, strobe_pin_in = 1, latch_pin_in = 1;
    logic cpu_strobe = 0, cpu_latch = 0, er, pready, pslverr, strobe_pin_out, strobe_pin_oe;
    logic strobe_pullup, latch_pin_out, latch_pin_oe, latch_pullup, core_run, code_secure;
    logic flash_prog_mode, aux_irq, watchdog_tick;
    logic [7:0] watchdog_period, v;
    int err_count = 0, n_tests = 0, cyc = 0, t0, t1, hmd;
    logic [11:0] ra [6] = '{OFF_MS_DIV_LOW, OFF_MS_DIV_HIGH, OFF_HMS_DIV, OFF_MS_PERIOD,
        OFF_SEC_PERIOD, OFF_WDOG_CTRL};
    logic [7:0] re [6] = '{RST_MS_DIV[7:0], RST_MS_DIV[15:8], RST_HMS_DIV, 8'(RST_PERIOD),
        8'(RST_PERIOD), RST_WDOG};
    system_tick_interrupts DUT (.core_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .external_code_select_pin, .strobe_pin_in, .latch_pin_in,
        .cpu_strobe, .cpu_latch, .strobe_pin_out, .strobe_pin_oe, .strobe_pullup, .latch_pin_out,
        .latch_pin_oe, .latch_pullup, .core_run, .code_secure, .flash_prog_mode, .aux_irq,
        .watchdog_tick, .watchdog_period);
    // ****************************************
    // clock, cycle count, timeout
    // ****************************************
    initial
    begin
        forever #25 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        cpu_strobe <= 1'($urandom_range(1));
        cpu_latch <= 1'($urandom_range(1));
        if (cyc == 160000)
        begin
            err_count++;
            summarize();
        end
    end
    // ****************************************
    // helpers
    // ****************************************
    function automatic int gap(input int n, input int unit);
        return (n + 1) * unit;
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        // pready ends this wait; without it only the bench timeout does
        do
            @(posedge core_clk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    // clears both pending flags, then stamps the next interrupt
    task automatic next_irq(output int t);
        apb(1, OFF_AUX_PENDING, 32'h0000_0003);
        repeat (2) @(negedge core_clk);
        while (aux_irq !== 1'b1)
            @(negedge core_clk);
        t = cyc;
    endtask
    task automatic meas(input logic [11:0] a, input int n, input int unit);
        apb(1, a, 32'(n) | 32'h0000_0080);
        next_irq(t0);
        next_irq(t0);
        next_irq(t1);
        check("irq period", t1 - t0, gap(n, unit));
    endtask
    // a write without the load bit waits for the running count
    task automatic defer(input logic [11:0] a, input int p, input int q, input int unit);
        meas(a, p, unit);
        apb(1, a, 32'(q));
        next_irq(t1);
        check("deferred old", t1 - t0, gap(p, unit) * 2);
        next_irq(t0);
        check("deferred new", t0 - t1, gap(q, unit));
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ****************************************
    // tests
    // ****************************************
    initial
    begin
        void'($urandom(32'he2a1edc2));
        repeat (4) @(posedge core_clk);
        rstn <= 1;
        check("startup pins", 32'({strobe_pullup, latch_pullup, strobe_pin_oe, core_run}),
            32'h0000_000c);
        foreach (ra[i])
        begin
            apb(0, ra[i], 0);
            check("reset value", rd, 32'(re[i]));
        end
        apb(0, 12'h000, 0);
        check("unmapped err", 32'(er), 32'h0000_0001);
        check("unmapped data", rd, 32'h0000_0000);
        v = 8'($urandom);
        apb(1, OFF_WDOG_CTRL, 32'(v));
        apb(0, OFF_WDOG_CTRL, 0);
        check("watchdog rd", rd, 32'(v));
        check("watchdog out", 32'(watchdog_period), 32'(v));
        apb(1, OFF_MS_DIV_LOW, 32'(MSD - 1));
        apb(1, OFF_MS_DIV_HIGH, 0);
        apb(1, OFF_HMS_DIV, 2);
        apb(1, OFF_EXT_CTRL, 32'h0000_0020);
        $display("test registers done");
        while (core_run !== 1'b1)
            @(negedge core_clk);
        check("running pins", 32'({strobe_pullup, latch_pullup, latch_pin_oe}), 32'h0000_0001);
        apb(0, OFF_STATUS, 0);
        check("status", rd, 32'h0000_0003);
        $display("test startup done");
        apb(1, OFF_AUX_ENABLE, 32'h0000_0010);
        meas(OFF_MS_PERIOD, 0, MSD);
        meas(OFF_MS_PERIOD, 127, MSD);
        defer(OFF_MS_PERIOD, $urandom_range(1, 9), $urandom_range(10, 20), MSD);
        apb(1, OFF_EXT_CTRL, 0);
        apb(1, OFF_AUX_PENDING, 32'h0000_0003);
        // longest period in use is 21 ms ticks
        repeat (gap(20, MSD) + 10) @(negedge core_clk);
        apb(0, OFF_AUX_PENDING, 0);
        check("gated irq", 32'({aux_irq, rd[BIT_PEND_MS]}), 32'h0000_0001);
        apb(1, OFF_EXT_CTRL, 32'h0000_0020);
        $display("test ms interrupt done");
        apb(1, OFF_AUX_ENABLE, 32'h0000_0080);
        meas(OFF_SEC_PERIOD, 0, 3 * MSD);
        defer(OFF_SEC_PERIOD, $urandom_range(1, 3), $urandom_range(4, 6), 3 * MSD);
        $display("test seconds interrupt done");
        hmd = $urandom_range(1, 6);
        apb(1, OFF_HMS_DIV, 32'(hmd));
        repeat (2) @(posedge watchdog_tick);
        @(negedge core_clk);
        t0 = cyc;
        @(posedge watchdog_tick);
        @(negedge core_clk);
        check("watchdog tick gap", cyc - t0, gap(hmd, MSD));
        $display("test watchdog tick done");
        @(posedge core_clk);
        rstn <= 0;
        strobe_pin_in <= 0;
        repeat (4) @(posedge core_clk);
        rstn <= 1;
        repeat (3) @(negedge core_clk);
        check("prog mode", 32'({flash_prog_mode, code_secure, strobe_pullup}),
            32'h0000_0005);
        $display("test programming mode done");
        summarize();
    end
endmodule
